// ### rtl/ppcc_pixel_port.sv
// Pixel input port and video clock controller top.
// Assumes I_CLOCK is the pixel clock and all pin inputs are asynchronous;
// configuration inputs come from logic in the I_CLOCK domain.
`timescale 1ns/1ps
`default_nettype none
module ppcc_pixel_port
  import ppcc_pkg::*;
(
  // Clock and reset
  input  wire logic              I_CLOCK,
  input  wire logic              I_NRST,
  // Pixel port pins
  input  wire logic              I_PIXEL_LATCH_STROBE,
  input  wire logic [WORD_W-1:0] I_PIXEL_WORD_A,
  input  wire logic [WORD_W-1:0] I_PIXEL_WORD_B,
  input  wire logic [PS_W-1:0]   I_PALETTE_SELECT_INPUTS_A,
  input  wire logic [PS_W-1:0]   I_PALETTE_SELECT_INPUTS_B,
  input  wire logic              I_SYNC_N,
  input  wire logic              I_BLANK_N,
  input  wire logic              I_VSYNC_N,
  input  wire logic              I_SHIFT_CLOCK_IN,
  // Configuration
  input  wire logic              I_MULTIPLEX_RATE_SELECT,
  input  wire logic [1:0]        I_CLOCK_DIVIDE_SELECT,
  input  wire logic              I_SYNC_ON_GREEN_ENABLE,
  input  wire logic              I_SYNC_OUTPUT_ENABLE,
  input  wire logic              I_PALETTE_MATCH_BIT0,
  input  wire logic              I_PALETTE_MATCH_BIT1,
  input  wire logic              I_CALIBRATION_STEP_ONE,
  input  wire logic              I_CALIBRATION_STEP_TWO,
  input  wire logic              I_CALIBRATE_EACH_VSYNC,
  // Palette path stream
  output logic                   O_PIXEL_VALID,
  output logic [WORD_W-1:0]      O_PIXEL_DATA,
  output logic                   O_OUTPUT_ENABLE,
  output logic                   O_BLANK_FORCE,
  output logic                   O_SYNC_FORCE,
  output logic                   O_SYNC_ON_GREEN,
  // Clock and sync pins
  output logic                   O_LATCH_STROBE_OUT,
  output logic                   O_PROGRAMMABLE_CLOCK_OUT,
  output logic                   O_SHIFT_CLOCK_OUT,
  output logic                   O_SEPARATE_SYNC_OUT_N,
  // Status
  output logic                   O_CALIBRATED
);

  // Pin synchroniser stages
  logic [PIN_W-1:0] pin_meta_reg;   // First stage, read by second only
  logic [PIN_W-1:0] pin_sync_reg;   // Second stage, safe to use
  logic             strobe_prev_reg; // Strobe one clock earlier

  // Decoded synchronised fields
  logic              strobe_s;
  logic              capture;       // Strobe rising edge
  logic              vsync_fall;    // Vertical sync start
  logic [WORD_W-1:0] word_a_s;
  logic [WORD_W-1:0] word_b_s;
  logic [PS_W-1:0]   ps_a_s;
  logic [PS_W-1:0]   ps_b_s;
  logic              sync_n_s;
  logic              blank_n_s;
  logic              vsync_n_s;
  logic              sck_s;
  logic              vsync_prev_reg;

  // Calibration sequencer
  ppcc_cal_state_t cal_state_reg, cal_state_next;
  logic            step_one_prev_reg;
  logic            step_two_prev_reg;
  logic            cal_done_reg, cal_done_next;
  logic            restart;       // Divider realign pulse

  // Serializer outputs
  logic              ser_valid;
  logic [WORD_W-1:0] ser_word;
  logic [PS_W-1:0]   ser_ps;
  logic              ser_sync_n;
  logic              ser_blank_n;

  // Output stage registers
  logic              valid_reg, valid_next;
  logic [WORD_W-1:0] data_reg, data_next;
  logic              oen_reg, oen_next;
  logic              blank_f_reg, blank_f_next;
  logic              sync_f_reg, sync_f_next;
  logic              green_reg, green_next;
  logic              sep_sync_reg, sep_sync_next;
  logic              blank_cap_reg, blank_cap_next; // Blank of last capture
  logic              sck_out_reg, sck_out_next;
  logic [PS_W-1:0]   match_code;

  // Bundle every pin through two flip-flops
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      pin_meta_reg    <= PIN_RST;
      pin_sync_reg    <= PIN_RST;
      strobe_prev_reg <= PIN_RST[PIN_STROBE]; // No false edge
      vsync_prev_reg  <= 1'b1;
    end else begin
      pin_meta_reg    <= {I_PIXEL_LATCH_STROBE, I_SHIFT_CLOCK_IN, I_VSYNC_N,
                          I_SYNC_N, I_BLANK_N, I_PALETTE_SELECT_INPUTS_B,
                          I_PALETTE_SELECT_INPUTS_A, I_PIXEL_WORD_B,
                          I_PIXEL_WORD_A};
      pin_sync_reg    <= pin_meta_reg;
      strobe_prev_reg <= strobe_s;
      vsync_prev_reg  <= vsync_n_s;
    end
  end

  // Field decode; data and strobe share one delay so stay aligned
  assign strobe_s   = pin_sync_reg[PIN_STROBE];
  assign sck_s      = pin_sync_reg[PIN_SCK];
  assign vsync_n_s  = pin_sync_reg[PIN_VSYNC_N];
  assign sync_n_s   = pin_sync_reg[PIN_SYNC_N];
  assign blank_n_s  = pin_sync_reg[PIN_BLANK_N];
  assign ps_b_s     = pin_sync_reg[PIN_PSB_LO +: PS_W];
  assign ps_a_s     = pin_sync_reg[PIN_PSA_LO +: PS_W];
  assign word_b_s   = pin_sync_reg[PIN_WB_LO +: WORD_W];
  assign word_a_s   = pin_sync_reg[PIN_WA_LO +: WORD_W];
  // Edge found in the pixel clock domain, any strobe phase works
  assign capture    = strobe_s & ~strobe_prev_reg;
  assign vsync_fall = ~vsync_n_s & vsync_prev_reg;
  assign match_code = {I_PALETTE_MATCH_BIT1, I_PALETTE_MATCH_BIT0};

  // Calibration sequence: step one, then step two, or each vsync
  always_comb begin
    cal_state_next = cal_state_reg;
    cal_done_next  = cal_done_reg;
    restart        = 1'b0;
    unique case (cal_state_reg)
      CAL_IDLE: begin
        // Arm on a rising step one bit
        if (I_CALIBRATION_STEP_ONE && !step_one_prev_reg) begin
          cal_state_next = CAL_ARMED;
        end else if (I_CALIBRATE_EACH_VSYNC && vsync_fall) begin
          cal_state_next = CAL_WAIT_EDGE;
        end
      end
      CAL_ARMED: begin
        // Complete the pair on a rising step two bit
        if (I_CALIBRATION_STEP_TWO && !step_two_prev_reg) begin
          cal_state_next = CAL_WAIT_EDGE;
        end
      end
      CAL_WAIT_EDGE: begin
        // Realign the dividers to the next strobe edge
        if (capture) begin
          restart        = 1'b1;
          cal_done_next  = 1'b1;
          cal_state_next = CAL_IDLE;
        end
      end
    endcase
  end

  // Calibration state registers
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      cal_state_reg     <= CAL_IDLE;
      cal_done_reg      <= 1'b0;
      step_one_prev_reg <= 1'b0;
      step_two_prev_reg <= 1'b0;
    end else begin
      cal_state_reg     <= cal_state_next;
      cal_done_reg      <= cal_done_next;
      step_one_prev_reg <= I_CALIBRATION_STEP_ONE;
      step_two_prev_reg <= I_CALIBRATION_STEP_TWO;
    end
  end

  // Load strobe and programmable clock, both modes
  ppcc_clock_divider u_divider (
    .i_clock       (I_CLOCK),
    .i_nrst        (I_NRST),
    .i_mux_2to1    (I_MULTIPLEX_RATE_SELECT),
    .i_div_sel     (I_CLOCK_DIVIDE_SELECT),
    .i_restart     (restart),
    .o_load_strobe (O_LATCH_STROBE_OUT),
    .o_prog_clock  (O_PROGRAMMABLE_CLOCK_OUT)
  );

  // Capture and serialize the pixel pair
  ppcc_serializer u_serializer (
    .i_clock    (I_CLOCK),
    .i_nrst     (I_NRST),
    .i_capture  (capture),
    .i_mux_2to1 (I_MULTIPLEX_RATE_SELECT),
    .i_word_a   (word_a_s),
    .i_word_b   (word_b_s),
    .i_ps_a     (ps_a_s),
    .i_ps_b     (ps_b_s),
    .i_sync_n   (sync_n_s),
    .i_blank_n  (blank_n_s),
    .o_valid    (ser_valid),
    .o_word     (ser_word),
    .o_ps       (ser_ps),
    .o_sync_n   (ser_sync_n),
    .o_blank_n  (ser_blank_n)
  );

  // Output stage, one pixel clock after the serializer
  always_comb begin
    valid_next     = ser_valid;
    data_next      = ser_word;
    // Per-pixel select compare gates all three currents
    oen_next       = ser_valid && (ser_ps == match_code);
    blank_f_next   = ~ser_blank_n;
    sync_f_next    = ~ser_sync_n;
    // Sync reaches green only when enabled
    green_next     = ~ser_sync_n & I_SYNC_ON_GREEN_ENABLE;
    // Separate sync carries the same pipeline delay as pixels
    sep_sync_next  = I_SYNC_OUTPUT_ENABLE ? ser_sync_n : 1'b1;
    // Blank level follows each captured strobe edge
    blank_cap_next = capture ? blank_n_s : blank_cap_reg;
    sck_out_next   = sck_s & blank_cap_reg;
  end

  // Output stage registers
  always_ff @(posedge I_CLOCK) begin
    if (!I_NRST) begin
      valid_reg     <= 1'b0;
      data_reg      <= WORD_RST;
      oen_reg       <= 1'b0;
      blank_f_reg   <= 1'b1;
      sync_f_reg    <= 1'b0;
      green_reg     <= 1'b0;
      sep_sync_reg  <= 1'b1;
      blank_cap_reg <= 1'b0;
      sck_out_reg   <= 1'b0;
    end else begin
      valid_reg     <= valid_next;
      data_reg      <= data_next;
      oen_reg       <= oen_next;
      blank_f_reg   <= blank_f_next;
      sync_f_reg    <= sync_f_next;
      green_reg     <= green_next;
      sep_sync_reg  <= sep_sync_next;
      blank_cap_reg <= blank_cap_next;
      sck_out_reg   <= sck_out_next;
    end
  end

  assign O_PIXEL_VALID         = valid_reg;
  assign O_PIXEL_DATA          = data_reg;
  assign O_OUTPUT_ENABLE       = oen_reg;
  assign O_BLANK_FORCE         = blank_f_reg;
  assign O_SYNC_FORCE          = sync_f_reg;
  assign O_SYNC_ON_GREEN       = green_reg;
  assign O_SEPARATE_SYNC_OUT_N = sep_sync_reg;
  assign O_SHIFT_CLOCK_OUT     = sck_out_reg;
  assign O_CALIBRATED          = cal_done_reg;

  // First word reaches the pixel output two clocks after the edge
  a_first_word: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    capture |-> ##2 (O_PIXEL_VALID && O_PIXEL_DATA == $past(word_a_s, 2)))
    else $error("first pixel word not delivered");

  // Second word follows on the next pixel clock in 2:1
  a_second_word: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (capture && I_MULTIPLEX_RATE_SELECT && $stable(I_MULTIPLEX_RATE_SELECT))
    ##1 !capture
    |-> ##2 (O_PIXEL_VALID && O_PIXEL_DATA == $past(word_b_s, 3)))
    else $error("second pixel word out of order");

  // In 1:1 only one pixel per strobe edge
  a_single_pixel: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (capture && !I_MULTIPLEX_RATE_SELECT) ##1 !capture |-> ##2 !O_PIXEL_VALID)
    else $error("extra pixel in 1:1 mode");

  // Blank and sync taken on the same edge as the data
  a_sideband_edge: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    capture |-> ##2 (O_BLANK_FORCE == !$past(blank_n_s, 2)
                     && O_SYNC_FORCE == !$past(sync_n_s, 2)))
    else $error("side-band not captured with data");

  // Mismatching select shuts the outputs down
  a_palette_gate: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (capture && ps_a_s != match_code && $stable(match_code))
    |-> ##2 !O_OUTPUT_ENABLE)
    else $error("outputs enabled on select mismatch");

  // Green sync suppressed while disabled
  a_green_sync: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (!I_SYNC_ON_GREEN_ENABLE && $past(!I_SYNC_ON_GREEN_ENABLE)
     && $past(I_NRST)) |-> !O_SYNC_ON_GREEN)
    else $error("sync on green while disabled");

  // Separate sync matches the pixel stream sync
  a_sep_sync: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (I_SYNC_OUTPUT_ENABLE && $past(I_SYNC_OUTPUT_ENABLE) && $past(I_NRST))
    |-> (O_SEPARATE_SYNC_OUT_N == !O_SYNC_FORCE))
    else $error("separate sync off the pixel pipeline");

  // Shift clock stops during blanking
  a_shift_gate: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (capture && !blank_n_s) ##1 !capture [*2] |-> !O_SHIFT_CLOCK_OUT)
    else $error("shift clock ran during blanking");

  // Vsync calibration realigns within one strobe period
  a_vsync_cal: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
    (cal_state_reg == CAL_WAIT_EDGE && capture) |=> O_CALIBRATED)
    else $error("calibration did not complete");

endmodule : ppcc_pixel_port
`default_nettype wire

// ### rtl/ppcc_pkg.sv
// Constants, types and helpers for the pixel port and clock controller.
// Assumes one pixel clock domain; shared by all design files.
package ppcc_pkg;

  // Pixel word, side-band and divider counter widths
  localparam int WORD_W   = 24;
  localparam int PS_W     = 2;
  localparam int DIV_W    = 5;

  // Field positions in the synchronised pin bundle
  localparam int PIN_WA_LO    = 0;
  localparam int PIN_WB_LO    = 24;
  localparam int PIN_PSA_LO   = 48;
  localparam int PIN_PSB_LO   = 50;
  localparam int PIN_BLANK_N  = 52;
  localparam int PIN_SYNC_N   = 53;
  localparam int PIN_VSYNC_N  = 54;
  localparam int PIN_SCK      = 55;
  localparam int PIN_STROBE   = 56;
  localparam int PIN_W        = 57;

  // Programmable divider selection codes
  localparam logic [1:0] DIV_SEL_4  = 2'h0;
  localparam logic [1:0] DIV_SEL_8  = 2'h1;
  localparam logic [1:0] DIV_SEL_16 = 2'h2;
  localparam logic [1:0] DIV_SEL_32 = 2'h3;

  // Reset values and counter step
  localparam logic [WORD_W-1:0] WORD_RST   = 24'h000000;
  localparam logic [PS_W-1:0]   PS_RST     = 2'h0;
  localparam logic [PIN_W-1:0]  PIN_RST    = 57'h1c0000000000000;
  localparam logic [DIV_W-1:0]  CNT_RST    = 5'h00;
  localparam logic [DIV_W-1:0]  CNT_STEP   = 5'h01;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_ARMED,
    CAL_WAIT_EDGE
  } ppcc_cal_state_t;

  // Counter mask for divide-by-N
  function automatic logic [DIV_W-1:0] div_mask(input logic [1:0] sel);
    unique case (sel)
      DIV_SEL_4:  div_mask = 5'h03;
      DIV_SEL_8:  div_mask = 5'h07;
      DIV_SEL_16: div_mask = 5'h0f;
      DIV_SEL_32: div_mask = 5'h1f;
    endcase
  endfunction : div_mask

  // High-phase length (N/2) for divide-by-N
  function automatic logic [DIV_W-1:0] div_half(input logic [1:0] sel);
    unique case (sel)
      DIV_SEL_4:  div_half = 5'h02;
      DIV_SEL_8:  div_half = 5'h04;
      DIV_SEL_16: div_half = 5'h08;
      DIV_SEL_32: div_half = 5'h10;
    endcase
  endfunction : div_half

endpackage : ppcc_pkg

// ### rtl/ppcc_clock_divider.sv
// Load strobe and programmable clock generator.
// Assumes the pixel clock is I_CLOCK and restart comes from the same domain.
`timescale 1ns/1ps
`default_nettype none
module ppcc_clock_divider
  import ppcc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  // Control
  input  wire logic       i_mux_2to1,
  input  wire logic [1:0] i_div_sel,
  input  wire logic       i_restart,
  // Clock outputs
  output logic            o_load_strobe,
  output logic            o_prog_clock
);

  logic [DIV_W-1:0] cnt_reg;        // Free running pixel count
  logic [DIV_W-1:0] cnt_next;
  logic             load_reg;       // Load strobe level
  logic             load_next;
  logic             prog_reg;       // Programmable clock level
  logic             prog_next;
  logic [DIV_W-1:0] phase;          // Count within one output period

  // Next count and output levels
  always_comb begin
    cnt_next = i_restart ? CNT_RST : cnt_reg + CNT_STEP;
    // Even counts high for 2:1, steady high for undivided 1:1
    load_next = i_mux_2to1 ? ~cnt_next[0] : 1'b1;
    phase     = cnt_next & div_mask(i_div_sel);
    // High for the first N/2 counts; may only start at phase zero, an
    // even count, so a select change or reset cannot make an early edge
    prog_next = (phase < div_half(i_div_sel))
                && (prog_reg || phase == CNT_RST);
  end

  // Register state
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cnt_reg  <= CNT_RST;
      load_reg <= 1'b0;
      prog_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      load_reg <= load_next;
      prog_reg <= prog_next;
    end
  end

  assign o_load_strobe = load_reg;
  assign o_prog_clock  = prog_reg;

  // Programmable clock rises together with load strobe in 2:1 mode
  a_prog_with_load: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ($rose(prog_reg) && $past(i_mux_2to1) && $past(i_mux_2to1, 2)
     && !$past(i_restart)) |-> $rose(load_reg))
    else $error("programmable clock rose without load strobe");

  // Load strobe toggles every pixel clock in 2:1 mode
  a_load_halves: assert property (@(posedge i_clock) disable iff (!i_nrst)
    ($past(i_mux_2to1) && $past(i_mux_2to1, 2) && !$past(i_restart)
     && $past(i_nrst) && $past(i_nrst, 2))
    |-> (load_reg != $past(load_reg)))
    else $error("load strobe not at half pixel rate");

endmodule : ppcc_clock_divider
`default_nettype wire

// ### rtl/ppcc_serializer.sv
// Pixel capture and 2:1 / 1:1 serializer toward the palette path.
// Assumes inputs are already synchronised and capture is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module ppcc_serializer
  import ppcc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  // Capture request and mode
  input  wire logic              i_capture,
  input  wire logic              i_mux_2to1,
  // Captured fields
  input  wire logic [WORD_W-1:0] i_word_a,
  input  wire logic [WORD_W-1:0] i_word_b,
  input  wire logic [PS_W-1:0]   i_ps_a,
  input  wire logic [PS_W-1:0]   i_ps_b,
  input  wire logic              i_sync_n,
  input  wire logic              i_blank_n,
  // Serial pixel stream
  output logic                   o_valid,
  output logic [WORD_W-1:0]      o_word,
  output logic [PS_W-1:0]        o_ps,
  output logic                   o_sync_n,
  output logic                   o_blank_n
);

  logic              valid_reg, valid_next;     // Pixel present
  logic [WORD_W-1:0] word_reg, word_next;       // Current pixel
  logic [PS_W-1:0]   ps_reg, ps_next;           // Its palette select
  logic              sync_reg, sync_next;       // Sync of this pixel pair
  logic              blank_reg, blank_next;     // Blank of this pixel pair
  logic              pend_reg, pend_next;       // Second word waiting
  logic [WORD_W-1:0] held_word_reg, held_word_next;
  logic [PS_W-1:0]   held_ps_reg, held_ps_next;

  // Select what goes out next
  always_comb begin
    valid_next     = 1'b0;
    word_next      = word_reg;
    ps_next        = ps_reg;
    sync_next      = sync_reg;
    blank_next     = blank_reg;
    pend_next      = 1'b0;
    held_word_next = held_word_reg;
    held_ps_next   = held_ps_reg;
    if (i_capture) begin
      // First word and side-band on the strobe edge
      valid_next     = 1'b1;
      word_next      = i_word_a;
      ps_next        = i_ps_a;
      sync_next      = i_sync_n;
      blank_next     = i_blank_n;
      pend_next      = i_mux_2to1;
      held_word_next = i_word_b;
      held_ps_next   = i_ps_b;
    end else if (pend_reg) begin
      // Second word on the following pixel clock
      valid_next = 1'b1;
      word_next  = held_word_reg;
      ps_next    = held_ps_reg;
    end
  end

  // Register state on the pixel clock
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      valid_reg     <= 1'b0;
      word_reg      <= WORD_RST;
      ps_reg        <= PS_RST;
      sync_reg      <= 1'b1;
      blank_reg     <= 1'b1;
      pend_reg      <= 1'b0;
      held_word_reg <= WORD_RST;
      held_ps_reg   <= PS_RST;
    end else begin
      valid_reg     <= valid_next;
      word_reg      <= word_next;
      ps_reg        <= ps_next;
      sync_reg      <= sync_next;
      blank_reg     <= blank_next;
      pend_reg      <= pend_next;
      held_word_reg <= held_word_next;
      held_ps_reg   <= held_ps_next;
    end
  end

  assign o_valid   = valid_reg;
  assign o_word    = word_reg;
  assign o_ps      = ps_reg;
  assign o_sync_n  = sync_reg;
  assign o_blank_n = blank_reg;

endmodule : ppcc_serializer
`default_nettype wire

// ### bench/ppcc_fb_model.sv
// Frame buffer model: sets up one pixel pair, then raises the strobe.
// Assumes i_clock is the pixel clock; one strobe rise per run pulse.
`timescale 1ns/1ps
`default_nettype none
module ppcc_fb_model
  import ppcc_pkg::*;
(
  // Clock and request
  input  wire logic        i_clock,
  input  wire logic        i_run,
  input  wire logic [53:0] i_pair,
  // Pixel port pins
  output logic             o_strobe,
  output logic [53:0]      o_pins
);
  logic [2:0]  cnt;  // Cycles since run began
  logic [53:0] last; // Pair presented on the pins
  initial begin
    cnt = 3'h0;
    last = 54'h0;
    o_strobe = 1'b0;
  end
  // Data first, strobe rises three clocks later for setup
  // Run is sampled on the edge; pins and strobe move just after it
  always @(posedge i_clock) begin
    if (!i_run) cnt = 3'h0;
    else if (cnt != 3'h7) cnt = cnt + 3'h1;
    #1;
    if (cnt == 3'h1) last = i_pair;
    o_strobe = cnt[2];
  end
  // Idle pins show the inverse so stale data cannot pass
  assign o_pins = i_run ? last : ~last;
endmodule : ppcc_fb_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the pixel port and clock controller.
// Assumes the frame buffer model drives the pixel port pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppcc_pkg::*;
  logic clk = 0, nrst = 0, run = 0, sck = 0, mux = 1, sog = 0, soe = 0;
  logic m0 = 0, m1 = 0, s1 = 0, s2 = 0, vs_n = 1, each = 0;
  logic [1:0]  dsel = 2'h0;
  logic [53:0] pair = 54'h0;
  logic [53:0] pins;
  logic        strobe, valid, oe, bf, sf, sgr, lso, pco, sco, ssn, cal;
  logic [WORD_W-1:0] data;
  int          err_count = 0;
  int          n_compared = 0;
  always #10 clk = ~clk;
  ppcc_fb_model fb (.i_clock(clk), .i_run(run), .i_pair(pair),
    .o_strobe(strobe), .o_pins(pins));
  ppcc_pixel_port uut (.I_CLOCK(clk), .I_NRST(nrst),
    .I_PIXEL_LATCH_STROBE(strobe), .I_PIXEL_WORD_A(pins[23:0]),
    .I_PIXEL_WORD_B(pins[47:24]), .I_PALETTE_SELECT_INPUTS_A(pins[49:48]),
    .I_PALETTE_SELECT_INPUTS_B(pins[51:50]), .I_BLANK_N(pins[52]),
    .I_SYNC_N(pins[53]), .I_VSYNC_N(vs_n), .I_SHIFT_CLOCK_IN(sck),
    .I_MULTIPLEX_RATE_SELECT(mux), .I_CLOCK_DIVIDE_SELECT(dsel),
    .I_SYNC_ON_GREEN_ENABLE(sog), .I_SYNC_OUTPUT_ENABLE(soe),
    .I_PALETTE_MATCH_BIT0(m0), .I_PALETTE_MATCH_BIT1(m1),
    .I_CALIBRATION_STEP_ONE(s1), .I_CALIBRATION_STEP_TWO(s2),
    .I_CALIBRATE_EACH_VSYNC(each), .O_PIXEL_VALID(valid),
    .O_PIXEL_DATA(data), .O_OUTPUT_ENABLE(oe), .O_BLANK_FORCE(bf),
    .O_SYNC_FORCE(sf), .O_SYNC_ON_GREEN(sgr), .O_LATCH_STROBE_OUT(lso),
    .O_PROGRAMMABLE_CLOCK_OUT(pco), .O_SHIFT_CLOCK_OUT(sco),
    .O_SEPARATE_SYNC_OUT_N(ssn), .O_CALIBRATED(cal));
  // Verdict and end of run
  task stop_test;
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // One comparison, reported on mismatch
  task chk(input string nm, input logic [WORD_W-1:0] e, s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Step past n edges, settling after the last
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task timeout;
    err_count++;
    stop_test();
  endtask : timeout
  task do_reset;
    nrst = 0;
    tick(10);
    nrst = 1;
    tick(3);
  endtask : do_reset
  // Deliver one pair and judge the serial stream
  task send(input logic [23:0] a, b, input logic [1:0] pa, pb,
            input logic syn, blk);
    int i;
    pair = {syn, blk, pb, pa, b, a};
    run = 1;
    for (i = 0; i < 20 && valid !== 1'b1; i++) tick(1);
    if (i == 20) timeout();
    chk("word_a", a, data);
    chk("oe_a", ({m1, m0} == pa), oe);
    chk("blank", !blk, bf);
    chk("sync", !syn, sf);
    chk("green", !syn && sog, sgr);
    chk("sep_sync", soe ? syn : 1'b1, ssn);
    tick(1);
    chk("valid_b", mux, valid);
    if (mux) chk("word_b", b, data);
    if (mux) chk("oe_b", ({m1, m0} == pb), oe);
    run = 0;
    tick(4);
  endtask : send
  // Each select code and each sync and blank pair, one of the two sync enables on at a time
  task t_pairs;
    int k;
    for (k = 0; k < 4; k++) begin
      {m1, m0} = k[1:0];
      sog = ~k[1];
      soe = k[1];
      send(24'(24'ha5c300 + k), 24'(24'h5a3c00 + k), k[1:0], ~k[1:0], k[0],
           k[1]);
    end
  endtask : t_pairs
  // Shift clock follows input only while not blanked
  task t_shift;
    sck = 1;
    send(24'h111111, 24'h222222, 2'h0, 2'h0, 1'b1, 1'b0);
    chk("sck_blank", 1'b0, sco);
    send(24'h333333, 24'h444444, 2'h0, 2'h0, 1'b1, 1'b1);
    chk("sck_pass", 1'b1, sco);
    sck = 0;
    tick(4);
    chk("sck_low", 1'b0, sco);
  endtask : t_shift
  // Wait for a programmable clock rise; load strobe must rise with it
  task rise_pco(output int k);
    logic p, pl;
    for (k = 1; k < 80; k++) begin
      p = pco;
      pl = lso;
      tick(1);
      if (pco && !p) begin
        chk("load_rise", 2'h1, {pl, lso});
        return;
      end
    end
    timeout();
  endtask : rise_pco
  // Load strobe halves, programmable clock divides by each N
  task t_clocks;
    int n, i, hi, k;
    logic prev;
    for (i = 0; i < 4; i++) begin
      prev = lso;
      tick(1);
      chk("load_toggle", 1'b1, lso ^ prev);
    end
    for (n = 0; n < 4; n++) begin
      dsel = n[1:0];
      rise_pco(k);
      rise_pco(k);
      hi = 1;
      for (i = 1; i < (4 << n); i++) begin
        tick(1);
        hi += pco;
      end
      chk("prog_high", 2 << n, hi);
      rise_pco(k);
      chk("prog_period", 1, k);
    end
  endtask : t_clocks
  // 1:1 mode: one word per strobe, load strobe undivided
  task t_one;
    mux = 0;
    send(24'h0f0f0f, 24'hf0f0f0, {m1, m0}, 2'h0, 1'b1, 1'b1);
    chk("load_1to1", 1'b1, lso);
    tick(1);
    chk("load_1to1", 1'b1, lso);
    mux = 1;
  endtask : t_one
  // Calibration by step bits, then by vertical sync
  task t_cal;
    s1 = 1;
    tick(2);
    s2 = 1;
    tick(2);
    s1 = 0;
    s2 = 0;
    send(24'h123456, 24'h654321, {m1, m0}, 2'h0, 1'b1, 1'b1);
    chk("cal_steps", 1'b1, cal);
    do_reset();
    chk("cal_clear", 1'b0, cal);
    each = 1;
    vs_n = 0;
    tick(4);
    send(24'h777777, 24'h888888, {m1, m0}, 2'h0, 1'b1, 1'b1);
    chk("cal_vsync", 1'b1, cal);
  endtask : t_cal
  initial begin
    do_reset();
    chk("rst_valid", 1'b0, valid);
    chk("rst_sep_sync", 1'b1, ssn);
    chk("rst_cal", 1'b0, cal);
    t_pairs();
    t_shift();
    t_clocks();
    t_one();
    t_cal();
    stop_test();
  end
endmodule : tb
`default_nettype wire
